// file: stc_pkg.sv
package stc_pkg;

    // Widths of the capture path
    localparam int ADDR_W = 40;
    localparam int DATA_W = 32;
    localparam int ID_W = 7;
    localparam int OFF_W = 18;
    localparam int PG_W = 10;
    localparam int PT_AW = 8;
    localparam int PFN_W = ADDR_W - PG_W - 2;

    // Trigger source identifier and idle identifier
    localparam logic [ID_W-1:0] TRIG_ID = 7'h7d;
    localparam logic [ID_W-1:0] ID_NONE = 7'h00;

    // Marker in the upper bits of an identifier-change word
    localparam logic [DATA_W-ID_W-1:0] ID_TAG = 25'h1fffffe;

    // Translation stream of this buffer, arbitrary value
    localparam logic [3:0] STREAM_ID = 4'h1;

    // Sticky flag clear bit positions
    localparam int CLR_WRAP = 0;
    localparam int CLR_WM = 1;
    localparam int CLR_TRIG = 2;

    // Write sequencing phases
    typedef enum logic [1:0] {
        PH_ACCEPT,
        PH_XLATE,
        PH_WRITE
    } phase_t;

    // Whole control state of the capture buffer
    typedef struct packed {
        phase_t phase;
        logic rdy;
        logic stopped;
        logic [OFF_W-1:0] off;
        logic [OFF_W:0] fill;
        logic [ID_W-1:0] last_id;
        logic [ID_W-1:0] hold_id;
        logic [DATA_W-1:0] hold_data;
        logic need_id;
        logic trig_prev;
        logic triggered;
        logic wrap_pend;
        logic wm_pend;
        logic mem_valid;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_data;
        logic dedicated;
        logic nonsecure;
        logic [3:0] stream;
        logic irq;
        logic lpi_valid;
        logic [1:0] lpi_code;
    } cap_state_t;

    // Value after reset
    localparam cap_state_t CAP_RST = '{
        phase: PH_ACCEPT, last_id: ID_NONE, nonsecure: 1'b1,
        stream: STREAM_ID, default: '0};

endpackage

// file: page_table_if.sv
interface page_table_if;
    logic we;
    logic [stc_pkg::PT_AW-1:0] waddr;
    logic [stc_pkg::PFN_W-1:0] wdata;
    logic [stc_pkg::PT_AW-1:0] raddr;
    logic [stc_pkg::PFN_W-1:0] rdata;

    modport ram (input we, input waddr, input wdata, input raddr, output rdata);
    modport user (output we, output waddr, output wdata, output raddr, input rdata);
endinterface

// file: sync2.sv
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_ni,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_t;

    sync_t s;
    sync_t next_s;

    // Second stage reads only the first
    always_comb begin
        next_s.meta = d_i;
        next_s.q = s.meta;
    end

    // Two flops, cleared asynchronously
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.q;
endmodule

// file: page_ram.sv
module page_ram (
    // Clock
    input wire logic clk_i,
    // Table access
    page_table_if.ram pt
);
    typedef struct packed {
        logic [(1<<stc_pkg::PT_AW)-1:0][stc_pkg::PFN_W-1:0] mem;
        logic [stc_pkg::PFN_W-1:0] rdata;
    } ram_t;

    ram_t s;
    ram_t next_s;

    // Write port and registered read
    always_comb begin
        next_s = s;
        if (pt.we) begin
            next_s.mem[pt.waddr] = pt.wdata;
        end
        next_s.rdata = s.mem[pt.raddr];
    end

    // Table contents are not reset
    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    assign pt.rdata = s.rdata;
endmodule

// file: stc_buffer.sv
// Notes on behaviour
// RQ1: Dedicated buffer captures the trace macrocell stream.
// RQ2: Circular mode wraps writes past region end.
// RQ3: Base anywhere in low 40 address bits.
// RQ4: Large buffers split into granule-sized pages.
// RQ5: Two translation stages, ours plus iommu.
// RQ6: Own translation stream toward the iommu.
// RQ7: Contiguous physical mode bypasses page scattering.
// RQ8: Buffer placeable in non-secure memory.
// RQ9: Several sources interleaved with identifier framing.
// RQ10: Controls directly addressable, non-secure map.
// RQ11: Usable without platform specific software.
// RQ12: Firmware opens debug authentication before boot.
// RQ13: Only funnels, replicators, inline FIFO upstream.
// RQ14: Source trigger detected, may stop capture.
// RQ15: Trigger by identifier packet or dedicated line.
// RQ16: Trigger identifier ignored or stored, selectable.
// RQ17: Interrupt when circular write reaches top.
// RQ18: Interrupt when fill reaches programmed watermark.
// RQ19: Interrupt as wired level and message.
// RQ20: Control state survives processor warm reset.
// RQ21: Interrupts work without interrupt control registers.
// RQ22: Wrap to base, overwrite oldest data.
module stc_buffer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Capture configuration
    input wire logic enable_i, // RQ10 RQ11
    input wire logic circular_i,
    input wire logic sysmem_i,
    input wire logic scatter_i,
    input wire logic [stc_pkg::ADDR_W-1:0] base_addr_i,
    input wire logic [stc_pkg::OFF_W:0] size_words_i,
    input wire logic [stc_pkg::OFF_W:0] watermark_i,
    input wire logic trig_stop_i,
    input wire logic trig_store_i,
    // Interrupt configuration and clears
    input wire logic wrap_irq_en_i,
    input wire logic wm_irq_en_i,
    input wire logic [2:0] clear_i,
    // Page table load
    input wire logic pt_we_i,
    input wire logic [stc_pkg::PT_AW-1:0] pt_idx_i,
    input wire logic [stc_pkg::PFN_W-1:0] pt_pfn_i,
    // Trace bus from the macrocell
    input wire logic trace_valid_i, // RQ13
    input wire logic [stc_pkg::ID_W-1:0] trace_id_i,
    input wire logic [stc_pkg::DATA_W-1:0] trace_data_i,
    output logic trace_ready_o,
    // Dedicated trigger line
    input wire logic trig_pin_i,
    // Memory write port
    output logic mem_valid_o,
    output logic [stc_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [stc_pkg::DATA_W-1:0] mem_data_o,
    input wire logic mem_ready_i,
    output logic mem_dedicated_o,
    output logic mem_nonsecure_o,
    output logic [3:0] mem_stream_o,
    // Status
    output logic [stc_pkg::OFF_W-1:0] write_off_o,
    output logic [stc_pkg::OFF_W:0] fill_o,
    output logic capturing_o,
    output logic triggered_o,
    output logic wrap_pend_o,
    output logic wm_pend_o,
    // Interrupt delivery
    output logic irq_o,
    output logic lpi_valid_o,
    output logic [1:0] lpi_code_o
);
    stc_pkg::cap_state_t s;
    stc_pkg::cap_state_t next_s;

    logic rst_n;
    logic trig_sync;
    logic accept;
    logic is_trig;
    logic store;
    logic trig_ev;
    logic done;
    logic at_top;
    logic wrap_ev;
    logic wm_ev;
    logic full_stop;
    logic [stc_pkg::OFF_W-1:0] off_inc;

    page_table_if pt ();

    // Reset release; only this reset clears control state
    sync2 #(
        .W(1)
    ) u_rst_sync (
        .clk_i(clk_i),
        .rst_ni(nrst_i),
        .d_i(1'b1),
        .q_o(rst_n)
    ); // RQ20

    // Dedicated trigger line from the macrocell
    sync2 #(
        .W(1)
    ) u_trig_sync (
        .clk_i(clk_i),
        .rst_ni(rst_n),
        .d_i(trig_pin_i),
        .q_o(trig_sync)
    ); // RQ15

    // First-stage translation table
    page_ram u_page_ram (
        .clk_i(clk_i),
        .pt(pt)
    ); // RQ4

    // Table load from the control side
    assign pt.we = pt_we_i;
    assign pt.waddr = pt_idx_i;
    assign pt.wdata = pt_pfn_i;

    // Look up the page of the offset about to be written
    assign pt.raddr = next_s.off[stc_pkg::OFF_W-1:stc_pkg::PG_W]; // RQ4

    // Byte address of a word offset for the current mode
    function automatic logic [stc_pkg::ADDR_W-1:0] word_addr(
        input logic [stc_pkg::OFF_W-1:0] off,
        input logic [stc_pkg::PFN_W-1:0] pfn
    );
        logic [stc_pkg::ADDR_W-1:0] lin;
        lin = {{(stc_pkg::ADDR_W-stc_pkg::OFF_W-2){1'b0}}, off, 2'b00};
        if (!sysmem_i) begin
            word_addr = lin; // RQ1
        end else if (scatter_i) begin
            word_addr = {pfn, off[stc_pkg::PG_W-1:0], 2'b00}; // RQ4
        end else begin
            word_addr = base_addr_i + lin; // RQ3 RQ7
        end
    endfunction

    // Input side events
    always_comb begin
        accept = s.rdy & trace_valid_i;
        is_trig = trace_id_i == stc_pkg::TRIG_ID; // RQ15
        store = accept & (~is_trig | trig_store_i); // RQ16
        trig_ev = (trig_sync & ~s.trig_prev) | (accept & is_trig); // RQ14
    end

    // Write position bookkeeping
    always_comb begin
        done = (s.phase == stc_pkg::PH_WRITE) & s.mem_valid & mem_ready_i;
        at_top = {1'b0, s.off} == size_words_i - 1'b1;
        off_inc = s.off + 1'b1;
        wrap_ev = done & at_top & circular_i; // RQ17
        full_stop = done & at_top & ~circular_i;
        wm_ev = done & (s.fill + 1'b1 == watermark_i) & (s.fill < size_words_i); // RQ18
    end

    // Next state
    always_comb begin
        next_s = s;
        next_s.lpi_valid = 1'b0;
        next_s.trig_prev = trig_sync;
        next_s.dedicated = ~sysmem_i;
        next_s.nonsecure = 1'b1; // RQ8
        next_s.stream = stc_pkg::STREAM_ID; // RQ6

        // Capture run control
        if (!enable_i) begin
            next_s.stopped = 1'b0;
        end else if ((trig_ev & trig_stop_i) | full_stop) begin
            next_s.stopped = 1'b1; // RQ14
        end

        // Take a word off the trace bus
        if (store) begin
            next_s.hold_id = trace_id_i;
            next_s.hold_data = trace_data_i;
            next_s.need_id = trace_id_i != s.last_id; // RQ9
            next_s.last_id = trace_id_i;
            next_s.phase = stc_pkg::PH_XLATE;
        end

        // Build the outgoing word once the page is known
        if (s.phase == stc_pkg::PH_XLATE) begin
            next_s.phase = stc_pkg::PH_WRITE;
            next_s.mem_valid = 1'b1;
            next_s.mem_addr = word_addr(s.off, pt.rdata); // RQ5
            if (s.need_id) begin
                next_s.mem_data = {stc_pkg::ID_TAG, s.hold_id}; // RQ9
            end else begin
                next_s.mem_data = s.hold_data;
            end
        end

        // Word stored; advance and wrap the write position
        if (done) begin
            next_s.mem_valid = 1'b0;
            if (at_top) begin
                next_s.off = '0; // RQ2 RQ22
            end else begin
                next_s.off = off_inc;
            end
            if (s.fill < size_words_i) begin
                next_s.fill = s.fill + 1'b1;
            end
            if (s.need_id) begin
                next_s.need_id = 1'b0;
                next_s.phase = full_stop ? stc_pkg::PH_ACCEPT : stc_pkg::PH_XLATE;
            end else begin
                next_s.phase = stc_pkg::PH_ACCEPT;
            end
        end

        // Disabling restarts the region at the base
        if (!enable_i && s.phase == stc_pkg::PH_ACCEPT) begin
            next_s.off = '0;
            next_s.fill = '0;
            next_s.last_id = stc_pkg::ID_NONE;
        end

        // Sticky flags, a new event beats its clear
        next_s.triggered = (s.triggered & ~clear_i[stc_pkg::CLR_TRIG]) | trig_ev; // RQ14
        next_s.wrap_pend = (s.wrap_pend & ~clear_i[stc_pkg::CLR_WRAP]) | wrap_ev; // RQ17
        next_s.wm_pend = (s.wm_pend & ~clear_i[stc_pkg::CLR_WM]) | wm_ev; // RQ18

        // Wired level and message delivery
        next_s.irq = (next_s.wrap_pend & wrap_irq_en_i) | (next_s.wm_pend & wm_irq_en_i); // RQ21
        if ((wrap_ev & wrap_irq_en_i) | (wm_ev & wm_irq_en_i)) begin
            next_s.lpi_valid = 1'b1; // RQ19
            next_s.lpi_code = {wm_ev & wm_irq_en_i, wrap_ev & wrap_irq_en_i};
        end

        // Ready only while idle and running
        next_s.rdy = enable_i & ~next_s.stopped & (next_s.phase == stc_pkg::PH_ACCEPT);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= stc_pkg::CAP_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign trace_ready_o = s.rdy;
    assign mem_valid_o = s.mem_valid;
    assign mem_addr_o = s.mem_addr;
    assign mem_data_o = s.mem_data;
    assign mem_dedicated_o = s.dedicated;
    assign mem_nonsecure_o = s.nonsecure;
    assign mem_stream_o = s.stream;
    assign write_off_o = s.off;
    assign fill_o = s.fill;
    assign capturing_o = s.rdy;
    assign triggered_o = s.triggered;
    assign wrap_pend_o = s.wrap_pend;
    assign wm_pend_o = s.wm_pend;
    assign irq_o = s.irq;
    assign lpi_valid_o = s.lpi_valid;
    assign lpi_code_o = s.lpi_code;
endmodule

// file: stc_buffer_properties.sv
module stc_buffer_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Watched inputs
    input wire logic trace_valid_i,
    input wire logic [stc_pkg::ID_W-1:0] trace_id_i,
    input wire logic trig_store_i,
    input wire logic trig_stop_i,
    input wire logic scatter_i,
    input wire logic [stc_pkg::ADDR_W-1:0] base_addr_i,
    input wire logic mem_ready_i,
    input wire logic wrap_irq_en_i,
    // Watched outputs
    input wire logic trace_ready_o,
    input wire logic mem_valid_o,
    input wire logic [stc_pkg::ADDR_W-1:0] mem_addr_o,
    input wire logic [stc_pkg::DATA_W-1:0] mem_data_o,
    input wire logic mem_dedicated_o,
    input wire logic mem_nonsecure_o,
    input wire logic [3:0] mem_stream_o,
    input wire logic [stc_pkg::OFF_W-1:0] write_off_o,
    input wire logic triggered_o,
    input wire logic wrap_pend_o,
    input wire logic irq_o,
    input wire logic lpi_valid_o,
    input wire logic [1:0] lpi_code_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock domain
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Trace handshake and write launch
    // Dropped trigger words that do not stop capture leave ready up
    a_take_drops_ready: assert property (trace_valid_i && trace_ready_o
        && (trace_id_i != stc_pkg::TRIG_ID || trig_store_i || trig_stop_i)
        |=> !trace_ready_o)
        else $error("ready stayed high after a take");
    a_take_starts_write: assert property (trace_valid_i && trace_ready_o
        && (trace_id_i != stc_pkg::TRIG_ID || trig_store_i) |-> ##2 mem_valid_o)
        else $error("no memory write two cycles after a take");
    a_write_held: assert property (mem_valid_o && !mem_ready_i
        |=> mem_valid_o && $stable(mem_addr_o) && $stable(mem_data_o))
        else $error("pending write changed before acceptance");
    // Address forming and write attributes
    a_contig_addr: assert property (mem_valid_o && !mem_dedicated_o && !scatter_i
        |-> mem_addr_o == base_addr_i + {20'h0, write_off_o, 2'b00})
        else $error("contiguous address not base plus offset");
    a_ded_addr: assert property (mem_valid_o && mem_dedicated_o
        |-> mem_addr_o == {20'h0, write_off_o, 2'b00})
        else $error("dedicated address not offset times four");
    a_bus_attrs: assert property (mem_nonsecure_o && mem_stream_o == stc_pkg::STREAM_ID)
        else $error("write attributes not non-secure own stream");
    // Wrap, interrupt delivery and trigger stop
    a_wrap_to_base: assert property ($rose(wrap_pend_o) |-> write_off_o == '0)
        else $error("wrap flag without offset back at base");
    a_wrap_irq: assert property ($rose(wrap_pend_o) && $past(wrap_irq_en_i)
        |-> irq_o && lpi_valid_o && lpi_code_o[0])
        else $error("wrap event not delivered");
    a_trig_stops: assert property ($rose(triggered_o) && $past(trig_stop_i)
        |-> !trace_ready_o [*3])
        else $error("capture not stopped by trigger");
endmodule

// file: trace_src.sv
module trace_src (
    // Clock
    input wire logic clk_i,
    // Trace bus
    input wire logic ready_i,
    output logic valid_o,
    output logic [stc_pkg::ID_W-1:0] id_o,
    output logic [stc_pkg::DATA_W-1:0] data_o,
    // Dedicated trigger line
    output logic trig_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        valid_o = 1'b0;
        id_o = '0;
        data_o = '0;
        trig_o = 1'b0;
    end

    // One word, held until taken, then idle lines show inverted junk
    task automatic send(input logic [stc_pkg::ID_W-1:0] id, input logic [stc_pkg::DATA_W-1:0] d);
        logic r;
        @(posedge clk_i);
        valid_o <= 1'b1;
        id_o <= id;
        data_o <= d;
        do begin
            @(negedge clk_i);
            r = ready_i;
            @(posedge clk_i);
        end while (!r);
        valid_o <= 1'b0;
        id_o <= ~id;
        data_o <= ~d;
    endtask

    // Trigger pulse on the dedicated line
    task automatic pulse();
        @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        trig_o <= 1'b0;
    endtask
endmodule

// file: tb.sv
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", n, e, a); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    int n_mismatch = 0;
    int tests_run = 0;
    logic clk_i = 0, nrst_i = 0, enable_i = 0, circular_i = 1, sysmem_i = 1, scatter_i = 0;
    logic trig_stop_i = 0, trig_store_i = 1, wrap_irq_en_i = 1, wm_irq_en_i = 1;
    logic pt_we_i = 0, mem_ready_i = 0, trace_valid_i, trig_pin_i, trace_ready_o;
    logic [39:0] base_addr_i = '0, mem_addr_o;
    logic [18:0] size_words_i = 19'h8, watermark_i = 19'h3, fill_o;
    logic [2:0] clear_i = '0;
    logic [7:0] pt_idx_i = '0;
    logic [27:0] pt_pfn_i = '0;
    logic [6:0] trace_id_i;
    logic [31:0] trace_data_i, mem_data_o;
    logic mem_valid_o, mem_dedicated_o, mem_nonsecure_o, capturing_o, triggered_o;
    logic wrap_pend_o, wm_pend_o, irq_o, lpi_valid_o;
    logic [3:0] mem_stream_o;
    logic [17:0] write_off_o;
    logic [1:0] lpi_code_o, lpi_seen = '0;
    logic [39:0] wa[$];
    logic [31:0] wd[$];

    stc_buffer stc_buffer_inst (.clk_i, .nrst_i, .enable_i, .circular_i, .sysmem_i, .scatter_i,
        .base_addr_i, .size_words_i, .watermark_i, .trig_stop_i, .trig_store_i, .wrap_irq_en_i,
        .wm_irq_en_i, .clear_i, .pt_we_i, .pt_idx_i, .pt_pfn_i, .trace_valid_i, .trace_id_i,
        .trace_data_i, .trace_ready_o, .trig_pin_i, .mem_valid_o, .mem_addr_o, .mem_data_o,
        .mem_ready_i, .mem_dedicated_o, .mem_nonsecure_o, .mem_stream_o, .write_off_o, .fill_o,
        .capturing_o, .triggered_o, .wrap_pend_o, .wm_pend_o, .irq_o, .lpi_valid_o, .lpi_code_o);
    trace_src trace_src_inst (.clk_i, .ready_i(trace_ready_o), .valid_o(trace_valid_i),
        .id_o(trace_id_i), .data_o(trace_data_i), .trig_o(trig_pin_i));

    always #10 clk_i = ~clk_i;

    // Memory sink stalls every other cycle and logs writes and messages
    always @(posedge clk_i) begin
        mem_ready_i <= ~mem_ready_i;
        if (!enable_i) begin
            wa.delete();
            wd.delete();
        end else if (mem_valid_o && mem_ready_i) begin
            wa.push_back(mem_addr_o);
            wd.push_back(mem_data_o);
        end
        if (!enable_i)
            lpi_seen <= '0;
        else if (lpi_valid_o)
            lpi_seen <= lpi_seen | lpi_code_o;
    end

    // Disable, clear flags, enable afresh
    task restart();
        @(posedge clk_i);
        enable_i <= 1'b0;
        clear_i <= 3'h7;
        repeat (2) @(posedge clk_i);
        clear_i <= 3'h0;
        enable_i <= 1'b1;
    endtask

    task wait_wr(input int n);
        for (int i = 0; i < 60 && wa.size() < n; i++) @(posedge clk_i);
    endtask

    task t_contig();
        @(posedge clk_i);
        base_addr_i <= 40'h80_0000_1000;
        restart();
        trace_src_inst.send(7'h05, 32'hcafe0001);
        trace_src_inst.send(7'h05, 32'hcafe0002);
        wait_wr(3);
        `CHK("id word", {stc_pkg::ID_TAG, 7'h05}, wd[0])
        `CHK("data", 32'hcafe0002, wd[2])
        for (int i = 0; i < 3; i++)
            `CHK("addr", base_addr_i + 40'(4 * i), wa[i])
        `CHK("region", 1'b0, mem_dedicated_o)
    endtask

    task t_wrap();
        @(posedge clk_i);
        sysmem_i <= 1'b0;
        size_words_i <= 19'h4;
        restart();
        for (int i = 0; i < 4; i++) trace_src_inst.send(7'h11, 32'(i));
        wait_wr(5);
        repeat (2) @(posedge clk_i);
        `CHK("wrap flag", 1'b1, wrap_pend_o)
        `CHK("watermark flag", 1'b1, wm_pend_o)
        `CHK("irq", 1'b1, irq_o)
        `CHK("lpi codes", 2'b11, lpi_seen)
        `CHK("offset", 18'h1, write_off_o)
        `CHK("wrapped addr", 40'h0, wa[4])
        `CHK("dedicated", 1'b1, mem_dedicated_o)
        `CHK("fill", 19'h4, fill_o)
        `CHK("capturing", 1'b1, capturing_o)
        clear_i <= 3'h3;
        @(posedge clk_i);
        clear_i <= 3'h0;
        repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'b0, irq_o)
    endtask

    task t_trig();
        @(posedge clk_i);
        trig_stop_i <= 1'b1;
        trig_store_i <= 1'b0;
        restart();
        trace_src_inst.send(stc_pkg::TRIG_ID, 32'h1);
        repeat (6) @(posedge clk_i);
        `CHK("trig id", 1'b1, triggered_o)
        `CHK("stopped", 1'b0, trace_ready_o)
        `CHK("dropped", 0, wa.size())
        trig_stop_i <= 1'b0;
        trig_store_i <= 1'b1;
        restart();
        trace_src_inst.send(stc_pkg::TRIG_ID, 32'h5a5a);
        wait_wr(2);
        `CHK("stored id", {stc_pkg::ID_TAG, stc_pkg::TRIG_ID}, wd[0])
        `CHK("payload", 32'h5a5a, wd[1])
        trig_stop_i <= 1'b1;
        restart();
        trace_src_inst.pulse();
        repeat (6) @(posedge clk_i);
        `CHK("trig pin", 1'b1, triggered_o)
        `CHK("pin stop", 1'b0, trace_ready_o)
        `CHK("pin capturing", 1'b0, capturing_o)
        trig_stop_i <= 1'b0;
    endtask

    task t_scatter();
        @(posedge clk_i);
        sysmem_i <= 1'b1;
        scatter_i <= 1'b1;
        size_words_i <= 19'h500;
        pt_we_i <= 1'b1;
        pt_pfn_i <= 28'h1234567;
        @(posedge clk_i);
        pt_idx_i <= 8'h1;
        pt_pfn_i <= 28'h89abcde;
        @(posedge clk_i);
        pt_we_i <= 1'b0;
        restart();
        for (int i = 0; i < 1024; i++) trace_src_inst.send(7'h33, 32'(i));
        wait_wr(1025);
        `CHK("page 0 top", {28'h1234567, 10'h3ff, 2'b00}, wa[1023])
        `CHK("page 1 base", {28'h89abcde, 10'h000, 2'b00}, wa[1024])
        `CHK("stream", stc_pkg::STREAM_ID, mem_stream_o)
        `CHK("non-secure", 1'b1, mem_nonsecure_o)
    endtask

    // Own reset in mid-run clears state, capture resumes
    task t_reset();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("offset in reset", 18'h0, write_off_o)
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK("fill after reset", 19'h0, fill_o)
        `CHK("flag after reset", 1'b0, wm_pend_o)
        `CHK("capturing again", 1'b1, capturing_o)
    endtask

    task end_sim();
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_contig();
        t_wrap();
        t_trig();
        t_scatter();
        t_reset();
        end_sim();
    end

    // Hang guard
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        end_sim();
    end
endmodule

bind stc_buffer stc_buffer_checker stc_buffer_checker_inst (.clk_i, .nrst_i, .trace_valid_i,
    .trace_id_i, .trig_store_i, .trig_stop_i, .scatter_i, .base_addr_i, .mem_ready_i,
    .wrap_irq_en_i, .trace_ready_o, .mem_valid_o, .mem_addr_o, .mem_data_o, .mem_dedicated_o,
    .mem_nonsecure_o, .mem_stream_o, .write_off_o, .triggered_o, .wrap_pend_o, .irq_o,
    .lpi_valid_o, .lpi_code_o);
